// >>> radio_peer.sv
module radio_peer
  import radio_seq_pkg::*;
(
  input wire logic clk,
  input wire air_tx_s air_out,
  output air_rx_s air_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************
  // Far-end radio
  // ****************
  int drop = 0; // Acks lost on purpose
  int hold = 5; // Match to packet end
  logic ack_on = 1'b0;
  logic tx_q = 1'b0;
  initial air_in = '0;
  // One frame; fields turn over once it ends, not left stale
  task automatic frame(input logic [1:0] id, input logic na,
    input logic pay);
    repeat (10) @(posedge clk);
    air_in.addr_match <= 1'b1;
    @(posedge clk);
    air_in.addr_match <= 1'b0;
    repeat (hold) @(posedge clk);
    air_in <= {4'h3, na, id, pay}; // Packet done, checksum good
    @(posedge clk);
    air_in <= {4'h0, ~na, ~id, ~pay};
  endtask
  // Answer each finished send, unless told to lose it
  always @(posedge clk)
  begin
    tx_q <= air_out.tx_on;
    if (ack_on && tx_q && !air_out.tx_on)
    begin
      if (drop > 0)
        drop--;
      else
        fork
          frame(2'h0, 1'b0, 1'b0);
        join_none
    end
  end
endmodule

// >>> radio_seq.sv
`include "radio_seq_cfg.svh"
module radio_seq
  import radio_seq_pkg::*;
#(
  parameter int unsigned SETTLE_CYCLES = `SETTLE_CYC,
  parameter int unsigned LISTEN_CYCLES = `LISTEN_CYC,
  parameter int unsigned ARD_STEP_CYCLES = `ARD_STEP_CYC
)(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hsel,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic tx_queue_valid,
  input wire logic ack_pay_pending,
  input wire air_rx_s air_in,
  output air_tx_s air_out,
  output logic tx_pop,
  output logic radio_interrupt
);

  // ********************
  // State
  // ********************
  typedef struct packed {
    seq_e st;
    logic [23:0] cnt;
    logic [31:0] ctrl;
    logic [31:0] cfg;
    logic [2:0] evt;
    logic [3:0] retransmit_count;
    logic [1:0] last_pid;
    logic pid_seen;
    logic ackpay_out;
    logic wr_pend;
    logic [11:0] wr_addr;
    logic [31:0] rdata;
    air_tx_s air;
    logic pop;
    logic irq;
    logic halt;
  } state_s;

  state_s s_r;
  state_s s_nxt;

  // Bits on air: preamble, address, payload, checksum bytes plus control
  function automatic logic [23:0] air_cycles(logic [31:0] c, logic [5:0] n);
    logic [10:0] bits;
    bits = 11'((1 + 3 + int'(c[`CFG_ADDRW_LSB +: 2]) + int'(n)
      + 1 + int'(c[`CFG_CRC2_BIT])) * 8 + `CTRL_FIELD_BITS);
    if (c[`CFG_RATE_BIT])
      air_cycles = 24'(int'(bits) * `BIT2M_CYC);
    else
      air_cycles = 24'(int'(bits) * `BIT1M_CYC);
  endfunction

  logic role_tx;
  logic enable;
  logic [3:0] limit;
  logic [23:0] ard_cyc;
  assign role_tx = s_r.cfg[`CFG_ROLE_BIT];
  assign enable = s_r.ctrl[`CTRL_ENABLE_BIT];
  assign limit = s_r.cfg[`CFG_LIMIT_LSB +: 4];
  assign ard_cyc = 24'((int'(s_r.cfg[`CFG_ARD_LSB +: 4]) + 1)
    * int'(ARD_STEP_CYCLES));

  // ********************
  // Sequencer and bus slave
  // ********************
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.pop = 1'b0;
    s_nxt.irq = 1'b0;
    s_nxt.cnt = (s_r.cnt != 24'h000000) ? s_r.cnt - 24'h000001 : s_r.cnt;
    // Bus write data phase
    if (s_r.wr_pend)
    begin
      s_nxt.wr_pend = 1'b0;
      unique case (s_r.wr_addr)
        `OFS_CTRL: s_nxt.ctrl = {31'h0, hwdata[0]};
        `OFS_CFG: s_nxt.cfg = hwdata;
        `OFS_EVENT: s_nxt.evt = s_r.evt & ~hwdata[2:0];
        default: ;
      endcase
    end
    // Address phase; reads answer in the data phase
    if (hsel && hready && htrans[1])
    begin
      s_nxt.wr_pend = hwrite;
      s_nxt.wr_addr = haddr[11:0];
      unique case (haddr[11:0])
        `OFS_CTRL: s_nxt.rdata = s_r.ctrl;
        `OFS_CFG: s_nxt.rdata = s_r.cfg;
        `OFS_STATUS: s_nxt.rdata = {24'h0, 4'(s_r.st), s_r.retransmit_count};
        `OFS_EVENT: s_nxt.rdata = {29'h0, s_r.evt};
        `OFS_OBSERVE: s_nxt.rdata = {28'h0, s_r.retransmit_count};
        default: s_nxt.rdata = 32'h0000_0000;
      endcase
    end
    // Sequencer; disabling drops to the static idle state
    if (!enable)
    begin
      s_nxt.st = st_idle;
      s_nxt.air = '0;
      s_nxt.halt = 1'b0; // Dropping enable rearms after max retries
    end
    else
    begin
      unique case (s_r.st)
        st_idle:
        begin
          // Hold off while the last packet is still being popped
          if (!s_r.halt
            && (role_tx ? (tx_queue_valid && !s_r.pop) : 1'b1))
          begin
            s_nxt.st = role_tx ? st_settle : st_rx_search;
            s_nxt.cnt = 24'(SETTLE_CYCLES);
            s_nxt.retransmit_count = 4'h0;
            s_nxt.air.rx_on = !role_tx;
          end
        end
        st_settle:
          if (s_r.cnt == 24'h000000)
          begin
            s_nxt.st = st_send;
            s_nxt.air.tx_on = 1'b1;
            s_nxt.cnt = air_cycles(s_r.cfg, s_r.cfg[`CFG_PLEN_LSB +: 6]);
          end
        st_send:
          if (s_r.cnt == 24'h000000)
          begin
            s_nxt.air.tx_on = 1'b0;
            if (s_r.cfg[`CFG_NOACK_BIT])
            begin
              s_nxt.st = st_irq_wait;
              s_nxt.cnt = s_r.cfg[`CFG_RATE_BIT] ? 24'(`IRQ2M_CYC)
                : 24'(`IRQ1M_CYC);
            end
            else
            begin
              s_nxt.st = st_listen;
              s_nxt.air.rx_on = 1'b1;
              s_nxt.cnt = 24'(LISTEN_CYCLES);
            end
          end
        st_irq_wait:
          if (s_r.cnt == 24'h000000)
          begin
            s_nxt.evt[1] = 1'b1;
            s_nxt.irq = 1'b1;
            s_nxt.pop = 1'b1;
            s_nxt.st = st_idle;
          end
        st_listen:
          if (air_in.addr_match)
            s_nxt.st = st_rx_pkt;
          else if (s_r.cnt == 24'h000000)
          begin
            s_nxt.air.rx_on = 1'b0;
            s_nxt.st = st_retry_wait;
            s_nxt.cnt = ard_cyc;
          end
        st_rx_pkt:
          if (air_in.pkt_done)
          begin
            s_nxt.air.rx_on = 1'b0;
            if (air_in.crc_ok)
            begin
              s_nxt.evt[1] = 1'b1;
              s_nxt.evt[0] = s_r.evt[0] | air_in.has_payload;
              s_nxt.irq = 1'b1;
              s_nxt.pop = 1'b1;
              s_nxt.st = st_idle;
            end
            else
            begin
              s_nxt.st = st_retry_wait;
              s_nxt.cnt = ard_cyc;
            end
          end
        st_retry_wait:
          if (s_r.cnt == 24'h000000)
          begin
            if (s_r.retransmit_count >= limit)
            begin
              s_nxt.evt[2] = 1'b1; // queue kept, no pop
              s_nxt.halt = 1'b1; // no restart until enable toggles
              s_nxt.irq = 1'b1;
              s_nxt.st = st_idle;
            end
            else
            begin
              s_nxt.retransmit_count = s_r.retransmit_count + 4'h1;
              s_nxt.st = st_settle;
              s_nxt.cnt = 24'(SETTLE_CYCLES);
            end
          end
        st_rx_search:
          if (air_in.pkt_done && air_in.crc_ok)
          begin
            // Copies of an already seen packet are dropped but acked
            if (!(s_r.pid_seen && air_in.pid == s_r.last_pid))
            begin
              s_nxt.evt[0] = 1'b1;
              s_nxt.irq = 1'b1;
              s_nxt.last_pid = air_in.pid;
              s_nxt.pid_seen = 1'b1;
              if (s_r.ackpay_out)
              begin
                s_nxt.evt[1] = 1'b1;
                s_nxt.ackpay_out = 1'b0;
                s_nxt.pop = 1'b1;
              end
            end
            if (!air_in.no_ack)
            begin
              s_nxt.air.rx_on = 1'b0;
              s_nxt.st = st_ack_settle;
              s_nxt.cnt = 24'(SETTLE_CYCLES);
            end
          end
        st_ack_settle:
          if (s_r.cnt == 24'h000000)
          begin
            s_nxt.st = st_ack_send;
            s_nxt.air.tx_on = 1'b1;
            s_nxt.air.ack_pay = s_r.cfg[`CFG_ACKPAY_BIT]
              && ack_pay_pending;
            s_nxt.cnt = air_cycles(s_r.cfg, 6'h00);
          end
        st_ack_send:
          if (s_r.cnt == 24'h000000)
          begin
            if (s_r.air.ack_pay && !s_r.ackpay_out)
              s_nxt.ackpay_out = 1'b1;
            s_nxt.air = '0;
            s_nxt.air.rx_on = 1'b1;
            s_nxt.st = st_rx_search;
          end
        default: s_nxt.st = st_idle;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_r <= '0;
      s_r.st <= st_idle;
      s_r.cfg <= `CFG_RESET;
    end
    else
      s_r <= s_nxt;
  end

  // ********************
  // Outputs
  // ********************
  assign hrdata = s_r.rdata;
  assign hreadyout = 1'b1; // Zero wait states
  assign hresp = 1'b0;
  assign air_out = s_r.air;
  assign tx_pop = s_r.pop;
  assign radio_interrupt = s_r.irq;

  // ********************
  // Checks
  // ********************
  // Queue pop only ever comes with the end interrupt
  chk_irq_on_end: assert property (
    @(posedge clk) disable iff (!rst_n)
    s_r.pop |-> s_r.irq)
    else $error("pop without interrupt");
  // Listen window never reloaded past its bound
  chk_listen_bound: assert property (
    @(posedge clk) disable iff (!rst_n)
    s_r.st == st_listen |-> s_r.cnt <= 24'(LISTEN_CYCLES))
    else $error("listen window too long");
  // Radio keys up only once the settle count ran out
  chk_send_after_settle: assert property (
    @(posedge clk) disable iff (!rst_n)
    $rose(s_r.air.tx_on) |-> $past(s_r.cnt) == 24'h000000)
    else $error("send started early");
  // Acked send turns straight round into receive
  chk_turn_to_rx: assert property (
    @(posedge clk) disable iff (!rst_n)
    (s_r.st == st_send && s_nxt.st == st_listen) |=> s_r.air.rx_on)
    else $error("no turnaround to receive");
  // Retry limit keeps the packet queued
  chk_maxrt_keep: assert property (
    @(posedge clk) disable iff (!rst_n)
    ($rose(s_r.evt[2]) && enable) |-> !s_r.pop)
    else $error("payload dropped at retry limit");
  // Once an address matched, stay until the packet ends
  chk_rx_hold: assert property (
    @(posedge clk) disable iff (!rst_n)
    (s_r.st == st_rx_pkt && !air_in.pkt_done && enable)
    |=> s_r.st == st_rx_pkt)
    else $error("left receive mid packet");
  // Good packet on the receiver schedules the ack
  chk_ack_after_rx: assert property (
    @(posedge clk) disable iff (!rst_n)
    (s_r.st == st_rx_search && s_nxt.st == st_ack_settle)
    |=> !s_r.air.tx_on ##1 s_r.st == st_ack_settle)
    else $error("ack not scheduled");
  // Retry counter never runs past the limit
  chk_retry_count: assert property (
    @(posedge clk) disable iff (!rst_n)
    s_r.retransmit_count <= limit || s_r.st == st_idle)
    else $error("retry count past limit");
  // Each interrupt, from a send or a receive, lasts one cycle
  chk_irq_pulse: assert property (
    @(posedge clk) disable iff (!rst_n)
    s_r.irq |=> !s_r.irq)
    else $error("interrupt longer than one cycle");
  // Good ack: data-sent, interrupt and pop together
  chk_ack_done: assert property (
    @(posedge clk) disable iff (!rst_n)
    (s_r.st == st_rx_pkt && air_in.pkt_done && air_in.crc_ok && enable)
    |=> s_r.irq && s_r.pop && s_r.evt[1])
    else $error("ack did not complete the send");
  // New packet on the receiver flags data-ready at once
  chk_rx_ready: assert property (
    @(posedge clk) disable iff (!rst_n)
    (s_r.st == st_rx_search && air_in.pkt_done && air_in.crc_ok && enable
    && !(s_r.pid_seen && air_in.pid == s_r.last_pid))
    |=> s_r.irq && s_r.evt[0])
    else $error("new packet not flagged");
  // No-ack send neither listens nor keys up while waiting
  chk_noack_quiet: assert property (
    @(posedge clk) disable iff (!rst_n)
    s_r.st == st_irq_wait |-> !s_r.air.rx_on && !s_r.air.tx_on)
    else $error("radio active before no-ack interrupt");
  // After the retry limit nothing restarts until enable toggles
  chk_maxrt_halt: assert property (
    @(posedge clk) disable iff (!rst_n)
    (s_r.halt && enable) |-> s_r.st == st_idle && !s_r.air.tx_on)
    else $error("restarted after retry limit");
  // Ack payload only when enabled and one was pending
  chk_ackpay_gate: assert property (
    @(posedge clk) disable iff (!rst_n)
    $rose(s_r.air.ack_pay)
    |-> $past(ack_pay_pending) && $past(s_r.cfg[`CFG_ACKPAY_BIT]))
    else $error("ack payload without pending data");

endmodule

// >>> radio_seq_cfg.svh
`ifndef RADIO_SEQ_CFG_SVH
`define RADIO_SEQ_CFG_SVH

// ********************
// Register offsets
// ********************
`define OFS_CTRL 12'h000
`define OFS_CFG 12'h004
`define OFS_STATUS 12'h008
`define OFS_EVENT 12'h00C
`define OFS_OBSERVE 12'h010
// Control fields
`define CTRL_ENABLE_BIT 0
`define CFG_ROLE_BIT 0
`define CFG_RATE_BIT 1
`define CFG_NOACK_BIT 2
`define CFG_ACKPAY_BIT 3
`define CFG_ADDRW_LSB 4
`define CFG_CRC2_BIT 6
`define CFG_PLEN_LSB 8
`define CFG_LIMIT_LSB 16
`define CFG_ARD_LSB 20
// Reset values
`define CFG_RESET 32'h0033_0050
// ********************
// Timing (ns and cycles at 5 ns)
// ********************
`define CLK_NS 5
`define SETTLE_NS 130000
`define SETTLE_CYC ((`SETTLE_NS + `CLK_NS - 1) / `CLK_NS)
`define LISTEN_NS 250000
`define LISTEN_CYC (`LISTEN_NS / `CLK_NS)
`define ARD_STEP_NS 250000
`define ARD_STEP_CYC (`ARD_STEP_NS / `CLK_NS)
`define IRQ1M_NS 8200
`define IRQ1M_CYC ((`IRQ1M_NS + `CLK_NS - 1) / `CLK_NS)
`define IRQ2M_NS 6000
`define IRQ2M_CYC ((`IRQ2M_NS + `CLK_NS - 1) / `CLK_NS)
`define BIT1M_NS 1000
`define BIT1M_CYC (`BIT1M_NS / `CLK_NS)
`define BIT2M_NS 500
`define BIT2M_CYC (`BIT2M_NS / `CLK_NS)
`define CTRL_FIELD_BITS 9
`endif

// >>> radio_seq_pkg.sv
package radio_seq_pkg;
  typedef enum {st_idle, st_settle, st_send, st_irq_wait, st_listen,
    st_rx_pkt, st_retry_wait, st_rx_search, st_ack_settle, st_ack_send}
    seq_e;
  typedef struct packed {
    logic start;
    logic addr_match;
    logic pkt_done;
    logic crc_ok;
    logic no_ack;
    logic [1:0] pid;
    logic has_payload;
  } air_rx_s;
  typedef struct packed {
    logic tx_on;
    logic rx_on;
    logic ack_pay;
  } air_tx_s;
endpackage

// >>> radio_seq_tb_top.sv
`include "radio_seq_cfg.svh"
module radio_seq_tb_top
  import radio_seq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = '0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = '0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic txq = 1'b0;
  logic ackp = 1'b0;
  air_rx_s air_in;
  air_tx_s air_out;
  logic tx_pop;
  logic irq;
  logic txp = 1'b0;
  logic [31:0] rd;
  int num_errors = 0;
  int checks = 0;
  int n_tx = 0;
  int n_pop = 0;
  int n;
  // Short counts so a retry run stays brief
  radio_seq #(.SETTLE_CYCLES(20), .LISTEN_CYCLES(40),
    .ARD_STEP_CYCLES(30)) DUT (.clk(clk), .rst_n(rst_n),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hsel(1'b1), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .tx_queue_valid(txq),
    .ack_pay_pending(ackp), .air_in(air_in),
    .air_out(air_out), .tx_pop(tx_pop), .radio_interrupt(irq));
  radio_peer peer (.clk(clk), .air_out(air_out), .air_in(air_in));
  initial forever #2.5 clk = ~clk;
  // Count send bursts and pops; the queue is one packet deep
  always @(posedge clk)
  begin
    txp <= air_out.tx_on;
    if (air_out.tx_on && !txp)
      n_tx++;
    if (tx_pop)
    begin
      n_pop++;
      txq <= 1'b0;
    end
  end
  // ****************
  // Shared tasks
  // ****************
  task automatic bus(input logic wr, input logic [31:0] a,
    input logic [31:0] d);
    @(posedge clk);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask
  task automatic chk(input string s, input logic [31:0] e,
    input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("BAD %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic rng(input string s, input int lo, input int hi,
    input int v);
    checks++;
    if (v < lo || v > hi)
    begin
      num_errors++;
      $display("BAD %s expected %0d..%0d seen %0d", s, lo, hi, v);
    end
  endtask
  function automatic logic hit(input int s);
    case (s)
      0: return air_out.tx_on;
      1: return !air_out.tx_on;
      2: return irq;
      default: return air_out.rx_on;
    endcase
  endfunction
  // Sample on the falling edge, where outputs have settled
  task automatic wait_for(input int s, input int lim);
    n = 0;
    @(negedge clk);
    while (hit(s) !== 1'b1 && n < lim)
    begin
      @(negedge clk);
      n++;
    end
    rng("wait", 0, lim - 1, n);
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // ****************
  // Scenarios
  // ****************
  task automatic t_regs();
    bus(1'b0, `OFS_CFG, 32'h0);
    chk("cfg reset", `CFG_RESET, rd);
    bus(1'b0, 32'h0000_0020, 32'h0);
    chk("unmapped", 32'h0, rd);
    chk("okay", 32'h0, hresp);
    $display("done regs");
  endtask
  task automatic t_noack();
    txq <= 1'b1;
    bus(1'b1, `OFS_CFG, 32'h0002_0007);
    bus(1'b1, `OFS_CTRL, 32'h1);
    wait_for(0, 60);
    rng("settle", 18, 22, n);
    wait_for(1, 6000);
    rng("air time", 4898, 4901, n);
    wait_for(2, 1400);
    rng("irq delay", 1198, 1202, n);
    chk("rx off", 32'h0, air_out.rx_on);
    bus(1'b0, `OFS_EVENT, 32'h0);
    chk("noack event", 32'h2, rd);
    bus(1'b1, `OFS_CTRL, 32'h0);
    repeat (30) @(posedge clk);
    $display("done no_ack");
  endtask
  // Acked send; lost acks force retries or the limit
  task automatic t_ack(input int dr, input int hd,
    input logic [31:0] ev, input int nt, input int np,
    input logic [31:0] cnt);
    int t0;
    int p0;
    t0 = n_tx;
    p0 = n_pop;
    txq <= 1'b1;
    peer.drop = dr;
    peer.hold = hd;
    peer.ack_on = 1'b1;
    bus(1'b1, `OFS_CFG, 32'h0002_0003);
    bus(1'b1, `OFS_EVENT, 32'h7);
    bus(1'b1, `OFS_CTRL, 32'h1);
    wait_for(0, 60);
    wait_for(1, 6000);
    wait_for(3, 3);
    wait_for(2, 40000);
    bus(1'b0, `OFS_EVENT, 32'h0);
    chk("event", ev, rd);
    bus(1'b0, `OFS_STATUS, 32'h0);
    chk("retries", cnt, rd & 32'hF);
    chk("sends", nt, n_tx - t0);
    chk("pops", np, n_pop - p0);
    bus(1'b1, `OFS_CTRL, 32'h0);
    peer.ack_on = 1'b0;
    repeat (30) @(posedge clk);
    $display("done ack drop %0d", dr);
  endtask
  task automatic t_rx();
    int p0;
    txq <= 1'b0;
    ackp <= 1'b1;
    peer.hold = 5;
    bus(1'b1, `OFS_CFG, 32'h0000_000A);
    bus(1'b1, `OFS_EVENT, 32'h7);
    bus(1'b1, `OFS_CTRL, 32'h1);
    wait_for(3, 40);
    peer.frame(2'h1, 1'b0, 1'b0);
    wait_for(2, 20);
    bus(1'b0, `OFS_EVENT, 32'h0);
    chk("rx event", 32'h1, rd);
    wait_for(0, 60);
    chk("ack payload", 32'h1, air_out.ack_pay);
    wait_for(1, 6000);
    bus(1'b1, `OFS_EVENT, 32'h7);
    p0 = n_pop;
    peer.frame(2'h1, 1'b0, 1'b0);
    wait_for(0, 80);
    wait_for(1, 6000);
    bus(1'b0, `OFS_EVENT, 32'h0);
    chk("copy event", 32'h0, rd);
    peer.frame(2'h2, 1'b0, 1'b0);
    wait_for(2, 20);
    bus(1'b0, `OFS_EVENT, 32'h0);
    chk("new event", 32'h3, rd);
    chk("rx pops", 32'h1, n_pop - p0);
    bus(1'b1, `OFS_CTRL, 32'h0);
    $display("done rx");
  endtask
  initial
  begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_noack();
    t_ack(0, 5, 32'h2, 1, 1, 32'h0);
    t_ack(1, 60, 32'h2, 2, 1, 32'h1);
    t_ack(9, 5, 32'h4, 3, 0, 32'h2);
    t_rx();
    report_and_stop();
  end
  // Whole run needs about 46k cycles; cut off at 80k, well past that
  initial
  begin
    #400us;
    num_errors++;
    report_and_stop();
  end
endmodule
